// *** pkg/dsod_defines.vh ***
// Contract
// RL1: Frequency word steps by adding or subtracting a preset per-channel offset.
// RL2: One 16-bit step-command write steps any set of channels, cumulatively.
// RL3: Pins may be enabled to step a specific channel up or down.
// RL4: Write-phase mode feeds the phase word into the loop filter as error.
// RL5: Controller rewrites the phase word at least sixty times loop bandwidth.
// RL6: Phase word is 32-bit two's complement, 50ps per step.
// RL7: Positive phase word speeds the output, negative slows it.
// RL8: 16-bit millisecond expiry timer clears the phase word or forces holdover.
// RL9: Controller must shrink the phase word over time.
// RL10: Closed-loop offset is active input's offset plus channel offset.
// RL11: Offset is recomputed whenever the active input changes.
// RL12: Offset plus measured phase error drives the loop filter.
// RL13: Lock declared after error stays within range for the programmed interval.
// RL14: Within threshold for half the interval, internal lock selects normal filter.
// RL15: Integer divider picks a fractional divider source, 32-bit divisor.
// RL16: New divisor acts at once; optional squelch gates clock during change.
// RL17: Integer divider makes continuous sysref and coarse delay in source periods.
// RL18: Fractional ratio is integer plus 43-bit numerator over two to 43.
// RL19: Fractional divider selects analog loop or digital loop as source.
// RL20: Fine phase moves by temporarily raising or lowering divider frequency.
// RL21: Direct mode uses external frequency word, positive means faster.
// RL22: Numeric mode steps numerator gradually, except first divider in jitter mode.
// RL23: Controller writes frequency word as 42-bit value sign-extended to 48.
// RL24: Expiry timer reloads on every phase word write, counts only when enabled.
`ifndef DSOD_DEFINES_VH
`define DSOD_DEFINES_VH
`define DSOD_OFS_CTRL      8'h00
`define DSOD_OFS_STEP_CMD  8'h04
`define DSOD_OFS_STEP_VAL  8'h08
`define DSOD_OFS_CH_SEL    8'h0c
`define DSOD_OFS_FSW_LO    8'h10
`define DSOD_OFS_FSW_HI    8'h14
`define DSOD_OFS_PSW       8'h18
`define DSOD_OFS_PSW_TMR   8'h1c
`define DSOD_OFS_IN_PHOFS  8'h20
`define DSOD_OFS_CH_PHOFS  8'h24
`define DSOD_OFS_LOCK_THR  8'h28
`define DSOD_OFS_LOCK_INT  8'h2c
`define DSOD_OFS_STATUS    8'h30
`define DSOD_OFS_FD_INT    8'h34
`define DSOD_OFS_FD_FRLO   8'h38
`define DSOD_OFS_FD_FRHI   8'h3c
`define DSOD_OFS_NCO_STEP  8'h40
`define DSOD_OFS_FINE_ADJ  8'h44
`define DSOD_OFS_FINE_LEN  8'h48
`define DSOD_OFS_ID_DIV    8'h4c
`define DSOD_OFS_ID_DLY    8'h50
// Control field positions
`define DSOD_MODE_LSB      0
`define DSOD_B_TMR_EN      2
`define DSOD_B_TMR_HOLD    3
`define DSOD_B_SQUELCH     4
`define DSOD_B_SYSREF      5
`define DSOD_B_FD_SRC      6
`define DSOD_B_JA_MODE     7
`define DSOD_B_NCO_EN      8
`define DSOD_B_PIN_EN      12
// Modes
`define DSOD_MODE_CLOSED   2'h0
`define DSOD_MODE_WFREQ    2'h1
`define DSOD_MODE_WPHASE   2'h2
// Reset values
`define DSOD_RST_CTRL      32'h0000_0000
`define DSOD_RST_FD_INT    32'h0000_0004
`define DSOD_RST_ID_DIV    32'h0000_0002
`define DSOD_RST_LOCK_INT  32'h0000_0100
// Timing
`define DSOD_CLK_NS        20
`define DSOD_MS_NS         1000000
`define DSOD_MS_CYC        (`DSOD_MS_NS / `DSOD_CLK_NS)
`endif

// *** hdl/dsod_core.v ***
`timescale 1ns/1ns
`include "dsod_defines.vh"
module dsod_core #(
    parameter NCH    = 4,             // Oscillator channels
    parameter NIN    = 4,             // Input references
    parameter MS_CYC = `DSOD_MS_CYC   // Clock cycles per millisecond
) (
    input  wire               ref_clk,        // 50 MHz clock
    input  wire               srst,           // Sync reset, active high
    input  wire               psel,           // APB select
    input  wire               penable,        // APB enable
    input  wire               pwrite,         // APB direction
    input  wire [7:0]         paddr,          // APB byte address
    input  wire [31:0]        pwdata,         // APB write data
    output reg  [31:0]        prdata,         // APB read data
    output reg                pready,         // APB ready
    output reg                pslverr,        // APB error
    input  wire [NCH-1:0]     pin_step_up,    // Step-up pins
    input  wire [NCH-1:0]     pin_step_down,  // Step-down pins
    input  wire [1:0]         active_ref,     // Active input index
    input  wire signed [31:0] phase_err,      // Measured phase error
    input  wire               fd_tick,        // One per divider output period
    output reg  [NCH*48-1:0]  frequency_steer_word, // Per-channel words
    output reg  signed [31:0] loop_filter_in, // Loop filter input
    output reg                holdover,       // Forced holdover
    output reg                locked,         // Lock declared
    output reg                lock_int,       // Internal lock, normal filter
    output reg  [31:0]        fd_int,         // Fractional divider integer
    output reg  [42:0]        fd_frac,        // Fractional divider numerator
    output reg                fd_src,         // 0 analog loop, 1 digital loop
    output reg                id_clk,         // Integer divider output
    output reg                sysref          // Continuous sysref
);
    // Register file
    reg [31:0]        ctrl;
    reg [15:0]        step_val [0:NCH-1];
    reg [1:0]         ch_sel;
    reg [47:0]        fsw [0:NCH-1];
    reg signed [31:0] psw;
    reg [15:0]        psw_tmr;
    reg signed [31:0] in_phofs [0:NIN-1];
    reg signed [31:0] ch_phofs;
    reg [31:0]        lock_thr;
    reg [31:0]        lock_intv;
    reg [42:0]        fd_frac_base;
    reg [42:0]        nco_left;
    reg signed [31:0] fine_adj;
    reg [31:0]        fine_len;
    reg [31:0]        id_div;
    reg [31:0]        id_dly;
    // Run state
    reg [15:0]        tmr_cnt;
    reg               tmr_run;
    reg [31:0]        ms_cnt;
    reg [NCH-1:0]     up_q;
    reg [NCH-1:0]     dn_q;
    reg [31:0]        lock_cnt;
    reg [31:0]        id_cnt;
    reg               squelch;
    reg               ack;
    reg [31:0]        rd_mux;
    reg               rd_ok;
    integer           i;

    wire       wr    = psel & penable & pready & pwrite;
    wire [1:0] mode  = ctrl[`DSOD_MODE_LSB+1:`DSOD_MODE_LSB];
    wire       ms_tk = (ms_cnt == MS_CYC - 1);
    wire [31:0] err_mag = phase_err[31] ? -phase_err : phase_err;
    wire       nco_ok = ctrl[`DSOD_B_NCO_EN] & ~ctrl[`DSOD_B_JA_MODE];
    wire [NCH-1:0] pin_en = ctrl[`DSOD_B_PIN_EN+NCH-1:`DSOD_B_PIN_EN];
    wire [NCH-1:0] up_ev = pin_step_up & ~up_q & pin_en;
    wire [NCH-1:0] dn_ev = pin_step_down & ~dn_q & pin_en;

    // Read mux and decode
    always @* begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `DSOD_OFS_CTRL:     rd_mux = ctrl;
            `DSOD_OFS_STEP_CMD: rd_mux = 32'h0000_0000;
            `DSOD_OFS_STEP_VAL: rd_mux = {16'h0000, step_val[ch_sel]};
            `DSOD_OFS_CH_SEL:   rd_mux = {30'h0, ch_sel};
            `DSOD_OFS_FSW_LO:   rd_mux = fsw[ch_sel][31:0];
            `DSOD_OFS_FSW_HI:   rd_mux = {16'h0000, fsw[ch_sel][47:32]};
            `DSOD_OFS_PSW:      rd_mux = psw;
            `DSOD_OFS_PSW_TMR:  rd_mux = {tmr_cnt, psw_tmr};
            `DSOD_OFS_IN_PHOFS: rd_mux = in_phofs[ch_sel];
            `DSOD_OFS_CH_PHOFS: rd_mux = ch_phofs;
            `DSOD_OFS_LOCK_THR: rd_mux = lock_thr;
            `DSOD_OFS_LOCK_INT: rd_mux = lock_intv;
            `DSOD_OFS_STATUS:   rd_mux = {28'h0, tmr_run, holdover, lock_int, locked};
            `DSOD_OFS_FD_INT:   rd_mux = fd_int;
            `DSOD_OFS_FD_FRLO:  rd_mux = fd_frac[31:0];
            `DSOD_OFS_FD_FRHI:  rd_mux = {21'h0, fd_frac[42:32]};
            `DSOD_OFS_NCO_STEP: rd_mux = nco_left[31:0];
            `DSOD_OFS_FINE_ADJ: rd_mux = fine_adj;
            `DSOD_OFS_FINE_LEN: rd_mux = fine_len;
            `DSOD_OFS_ID_DIV:   rd_mux = id_div;
            `DSOD_OFS_ID_DLY:   rd_mux = id_dly;
            default:            rd_ok  = 1'b0;
        endcase
    end

    // APB slave: one wait state, read data registered
    always @(posedge ref_clk) begin
        if (srst) begin
            ack     <= 1'b0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            ack     <= psel & penable & ~ack;
            pready  <= psel & penable & ~ack;
            pslverr <= psel & penable & ~ack & ~rd_ok;
            if (psel & penable & ~ack & ~pwrite)
                prdata <= rd_mux;
        end
    end

    // Configuration writes
    always @(posedge ref_clk) begin
        if (srst) begin
            ctrl      <= `DSOD_RST_CTRL;
            ch_sel    <= 2'h0;
            psw_tmr   <= 16'h0000;
            ch_phofs  <= 32'h0000_0000;
            lock_thr  <= 32'h0000_0000;
            lock_intv <= `DSOD_RST_LOCK_INT;
            fd_int    <= `DSOD_RST_FD_INT;
            fd_src    <= 1'b0;
            for (i = 0; i < NCH; i = i + 1)
                step_val[i] <= 16'h0000;
            for (i = 0; i < NIN; i = i + 1)
                in_phofs[i] <= 32'h0000_0000;
        end else begin
            fd_src <= ctrl[`DSOD_B_FD_SRC]; // [RL19]
            if (wr & ~pslverr) begin
                case (paddr)
                    `DSOD_OFS_CTRL:     ctrl      <= pwdata;
                    `DSOD_OFS_STEP_VAL: step_val[ch_sel] <= pwdata[15:0]; // [RL1]
                    `DSOD_OFS_CH_SEL:   ch_sel    <= pwdata[1:0];
                    `DSOD_OFS_PSW_TMR:  psw_tmr   <= pwdata[15:0];
                    `DSOD_OFS_IN_PHOFS: in_phofs[ch_sel] <= pwdata;
                    `DSOD_OFS_CH_PHOFS: ch_phofs  <= pwdata;
                    `DSOD_OFS_LOCK_THR: lock_thr  <= pwdata;
                    `DSOD_OFS_LOCK_INT: lock_intv <= pwdata;
                    `DSOD_OFS_FD_INT:   fd_int    <= pwdata; // [RL18]
                    default:            ;
                endcase
            end
        end
    end

    // Frequency words: direct write, register steps, pin steps
    always @(posedge ref_clk) begin
        if (srst) begin
            up_q <= {NCH{1'b0}};
            dn_q <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1)
                fsw[i] <= 48'h0;
        end else begin
            up_q <= pin_step_up;
            dn_q <= pin_step_down;
            for (i = 0; i < NCH; i = i + 1) begin
                if (wr & ~pslverr & (paddr == `DSOD_OFS_STEP_CMD) & pwdata[i])
                    fsw[i] <= fsw[i] + {32'h0, step_val[i]}; // [RL1] [RL2]
                else if (wr & ~pslverr & (paddr == `DSOD_OFS_STEP_CMD) & pwdata[8+i])
                    fsw[i] <= fsw[i] - {32'h0, step_val[i]}; // [RL1] [RL2]
                else if (up_ev[i])
                    fsw[i] <= fsw[i] + {32'h0, step_val[i]}; // [RL3]
                else if (dn_ev[i])
                    fsw[i] <= fsw[i] - {32'h0, step_val[i]}; // [RL3]
            end
            if (wr & ~pslverr & (paddr == `DSOD_OFS_FSW_LO))
                fsw[ch_sel][31:0] <= pwdata; // [RL21]
            if (wr & ~pslverr & (paddr == `DSOD_OFS_FSW_HI))
                fsw[ch_sel][47:32] <= pwdata[15:0]; // [RL21] [RL23]
        end
    end

    // Frequency words out, positive means faster
    always @(posedge ref_clk) begin
        if (srst)
            frequency_steer_word <= {NCH*48{1'b0}};
        else
            for (i = 0; i < NCH; i = i + 1)
                frequency_steer_word[i*48 +: 48] <= fsw[i]; // [RL21]
    end

    // Phase word and millisecond expiry timer
    always @(posedge ref_clk) begin
        if (srst) begin
            psw      <= 32'h0000_0000;
            tmr_cnt  <= 16'h0000;
            tmr_run  <= 1'b0;
            ms_cnt   <= 32'h0000_0000;
            holdover <= 1'b0;
        end else begin
            ms_cnt <= (ms_tk | ~tmr_run) ? 32'h0000_0000 : ms_cnt + 32'h1;
            if (wr & ~pslverr & (paddr == `DSOD_OFS_PSW)) begin
                psw      <= pwdata; // [RL6]
                tmr_cnt  <= psw_tmr; // [RL24]
                tmr_run  <= ctrl[`DSOD_B_TMR_EN] & (psw_tmr != 16'h0000);
                holdover <= 1'b0;
                ms_cnt   <= 32'h0000_0000;
            end else if (~ctrl[`DSOD_B_TMR_EN]) begin
                tmr_run <= 1'b0; // [RL24]
            end else if (tmr_run & ms_tk) begin
                tmr_cnt <= tmr_cnt - 16'h1; // [RL8]
                if (tmr_cnt == 16'h0001) begin
                    tmr_run <= 1'b0;
                    if (ctrl[`DSOD_B_TMR_HOLD])
                        holdover <= 1'b1; // [RL8]
                    else
                        psw <= 32'h0000_0000; // [RL8]
                end
            end
        end
    end

    // Loop filter input by mode
    always @(posedge ref_clk) begin
        if (srst)
            loop_filter_in <= 32'h0000_0000;
        else if (mode == `DSOD_MODE_WPHASE)
            loop_filter_in <= psw; // [RL4] [RL7]
        else if (mode == `DSOD_MODE_CLOSED)
            loop_filter_in <= phase_err + in_phofs[active_ref] + ch_phofs; // [RL10] [RL11] [RL12]
        else
            loop_filter_in <= 32'h0000_0000;
    end

    // Lock detector
    always @(posedge ref_clk) begin
        if (srst) begin
            lock_cnt <= 32'h0000_0000;
            locked   <= 1'b0;
            lock_int <= 1'b0;
        end else if (err_mag > lock_thr) begin
            lock_cnt <= 32'h0000_0000;
            locked   <= 1'b0;
            lock_int <= 1'b0;
        end else begin
            if (lock_cnt != 32'hffff_ffff)
                lock_cnt <= lock_cnt + 32'h1;
            if (lock_cnt >= {1'b0, lock_intv[31:1]})
                lock_int <= 1'b1; // [RL14]
            if (lock_cnt >= lock_intv)
                locked <= 1'b1; // [RL13]
        end
    end

    // Fractional divider: numeric stepping and fine phase slew
    always @(posedge ref_clk) begin
        if (srst) begin
            fd_frac_base <= 43'h0;
            nco_left     <= 43'h0;
            fine_adj     <= 32'h0000_0000;
            fine_len     <= 32'h0000_0000;
            fd_frac      <= 43'h0;
        end else begin
            if (wr & ~pslverr & (paddr == `DSOD_OFS_FD_FRLO))
                fd_frac_base[31:0] <= pwdata; // [RL18]
            else if (wr & ~pslverr & (paddr == `DSOD_OFS_FD_FRHI))
                fd_frac_base[42:32] <= pwdata[10:0]; // [RL18]
            else if (nco_left != 43'h0) begin
                fd_frac_base <= fd_frac_base + 43'h1; // [RL22]
            end
            if (wr & ~pslverr & (paddr == `DSOD_OFS_NCO_STEP) & nco_ok)
                nco_left <= {11'h0, pwdata}; // [RL22]
            else if (nco_left != 43'h0)
                nco_left <= nco_left - 43'h1;
            if (wr & ~pslverr & (paddr == `DSOD_OFS_FINE_ADJ))
                fine_adj <= pwdata;
            if (wr & ~pslverr & (paddr == `DSOD_OFS_FINE_LEN))
                fine_len <= pwdata; // [RL20]
            else if (fine_len != 32'h0000_0000)
                fine_len <= fine_len - 32'h1;
            // Smaller numerator raises frequency and advances edges
            if (fine_len != 32'h0000_0000)
                fd_frac <= fd_frac_base - {{11{fine_adj[31]}}, fine_adj}; // [RL20]
            else
                fd_frac <= fd_frac_base;
        end
    end

    // Integer divider with squelch, coarse delay and sysref
    always @(posedge ref_clk) begin
        if (srst) begin
            id_div  <= `DSOD_RST_ID_DIV;
            id_dly  <= 32'h0000_0000;
            id_cnt  <= 32'h0000_0000;
            id_clk  <= 1'b0;
            squelch <= 1'b0;
            sysref  <= 1'b0;
        end else begin
            sysref <= id_clk & ctrl[`DSOD_B_SYSREF]; // [RL17]
            if (wr & ~pslverr & (paddr == `DSOD_OFS_ID_DIV)) begin
                id_div  <= pwdata; // [RL15] [RL16]
                id_cnt  <= 32'h0000_0000;
                squelch <= ctrl[`DSOD_B_SQUELCH]; // [RL16]
                if (ctrl[`DSOD_B_SQUELCH])
                    id_clk <= 1'b0;
            end else if (wr & ~pslverr & (paddr == `DSOD_OFS_ID_DLY)) begin
                id_dly <= pwdata; // [RL17]
            end else if (fd_tick) begin
                if (id_dly != 32'h0000_0000) begin
                    id_dly <= id_dly - 32'h1; // [RL17]
                end else if (id_cnt >= id_div - 32'h1) begin
                    id_cnt  <= 32'h0000_0000;
                    id_clk  <= ~squelch & (id_div > 32'h1);
                    squelch <= 1'b0; // [RL16]
                end else begin
                    id_cnt <= id_cnt + 32'h1;
                    if (id_cnt == {1'b0, id_div[31:1]} - 32'h1)
                        id_clk <= 1'b0;
                end
            end
        end
    end
endmodule

// *** test/dsod_checker_sva.sv ***
`timescale 1ns/1ns
`include "dsod_defines.vh"
module dsod_checker (
    input wire        ref_clk,  // Clock
    input wire        srst,     // Sync reset
    input wire        psel,     // Select
    input wire        penable,  // Enable
    input wire        pwrite,   // Direction
    input wire [7:0]  paddr,    // Address
    input wire [31:0] pwdata,   // Write data
    input wire [31:0] prdata,   // Read data
    input wire        pready,   // Ready
    input wire        pslverr,  // Error
    input wire        locked,   // Lock declared
    input wire        lock_int, // Internal lock
    input wire [31:0] fd_int,   // Divider integer
    input wire [42:0] fd_frac   // Divider numerator
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Write completing at this edge
    wire wr_done = psel && penable && pwrite && pready;
    property p_ack;
        psel && penable && !pready |=> pready;
    endproperty
    a_ack: assert property (p_ack) else $error("ready not one cycle after access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rdata;
        $changed(prdata) |-> $past(psel && penable && !pwrite);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved outside a read");
    property p_lock_half;
        locked |-> lock_int;
    endproperty
    a_lock_half: assert property (p_lock_half) else $error("lock without internal lock");
    property p_lock_rise;
        $rose(locked) |-> $past(lock_int);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock before half interval");
    property p_int;
        wr_done && paddr == `DSOD_OFS_FD_INT |=> fd_int == $past(pwdata);
    endproperty
    a_int: assert property (p_int) else $error("divider integer not written");
    property p_frac;
        wr_done && paddr == `DSOD_OFS_FD_FRLO |=> ##1 fd_frac[31:0] == $past(pwdata, 2);
    endproperty
    a_frac: assert property (p_frac) else $error("divider numerator not written");
endmodule

// *** test/dsod_ctrl_model.sv ***
`timescale 1ns/1ns
`include "dsod_defines.vh"
module dsod_ctrl_model (
    input  wire         ref_clk, // Clock
    input  wire  [31:0] prdata,  // Read data
    input  wire         pready,  // Ready
    input  wire         pslverr, // Error
    output logic        psel,    // Select
    output logic        penable, // Enable
    output logic        pwrite,  // Direction
    output logic [7:0]  paddr,   // Address
    output logic [31:0] pwdata   // Write data
);
    // Bus idle from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    // One transfer, held until ready is sampled
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
    // Word sign-extended from 42 to 48 bits
    task automatic put_freq(input logic signed [41:0] w);
        logic [47:0] x;
        logic [31:0] r;
        logic        e;
        x = {{6{w[41]}}, w};
        xfer(1'b1, `DSOD_OFS_FSW_LO, x[31:0], r, e);
        xfer(1'b1, `DSOD_OFS_FSW_HI, {16'h0, x[47:32]}, r, e);
    endtask
    // Callers shrink the word on each rewrite, well above the loop rate
    task automatic put_phase(input logic signed [31:0] p);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, `DSOD_OFS_PSW, p, r, e);
    endtask
endmodule

// *** test/test_dco_steering_and_output_dividers.sv ***
`timescale 1ns/1ns
`include "dsod_defines.vh"
module test_dco_steering_and_output_dividers;
    logic               ref_clk, srst, psel, penable, pwrite, pready, pslverr, er;
    logic               fd_tick, holdover, locked, lock_int, fd_src, id_clk, sysref;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, seed, rd, fd_int;
    logic [3:0]         pin_up, pin_dn;
    logic [1:0]         active_ref;
    logic signed [31:0] phase_err, lfi, pw;
    logic [191:0]       fsw;
    logic [42:0]        fd_frac;
    logic [47:0]        acc [4];
    logic [31:0]        stv [4];
    logic [15:0]        cmds [3] = '{16'h000f, 16'h0a05, 16'h0f01};
    int                 fails, tests_run;
    dsod_core #(.MS_CYC(10)) i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_step_up(pin_up),
        .pin_step_down(pin_dn), .active_ref(active_ref), .phase_err(phase_err),
        .fd_tick(fd_tick), .frequency_steer_word(fsw), .loop_filter_in(lfi),
        .holdover(holdover), .locked(locked), .lock_int(lock_int), .fd_int(fd_int),
        .fd_frac(fd_frac), .fd_src(fd_src), .id_clk(id_clk), .sysref(sysref));
    dsod_ctrl_model i_ctrl (.ref_clk(ref_clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    // Clock and divider tick
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) fd_tick <= ~fd_tick;
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_ctrl.xfer(1'b1, a, d, rd, er);
    endtask
    // Expected words after a step command, add bit wins
    function automatic void apply_cmd(input logic [15:0] cmd);
        for (int c = 0; c < 4; c++) begin
            if (cmd[c])
                acc[c] = acc[c] + {16'h0, stv[c]};
            else if (cmd[8+c])
                acc[c] = acc[c] - {16'h0, stv[c]};
        end
    endfunction
    task automatic fsw_chk();
        for (int i = 0; i < 20 && fsw !== {acc[3], acc[2], acc[1], acc[0]}; i++)
            @(posedge ref_clk);
        for (int c = 0; c < 4; c++)
            check(fsw[c*48 +: 48], acc[c]);
    endtask
    task automatic lfi_chk(input logic [31:0] e, input int n);
        for (int i = 0; i < n && lfi !== e; i++)
            @(posedge ref_clk);
        check({32'h0, lfi}, {32'h0, e});
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        complete_run();
    end
    // Main sequence
    initial begin
        seed = 32'hb70fd58a;
        {fails, tests_run} = 64'h0;
        {srst, pin_up, pin_dn, active_ref, fd_tick} = 12'h800;
        phase_err = 32'sh0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        check(fd_int, 32'h4);
        i_ctrl.xfer(1'b0, 8'h7c, 32'h0, rd, er);
        check({er, rd}, 33'h1_0000_0000);
        wr(`DSOD_OFS_CTRL, 32'h1);
        wr(`DSOD_OFS_CH_SEL, 32'h0);
        i_ctrl.put_freq(-42'sd5);
        for (int c = 0; c < 4; c++) begin
            stv[c] = rnd() & 32'h0000_ffff;
            acc[c] = (c == 0) ? 48'hffff_ffff_fffb : 48'h0;
            wr(`DSOD_OFS_CH_SEL, 32'(c));
            wr(`DSOD_OFS_STEP_VAL, stv[c]);
        end
        fsw_chk();
        for (int k = 0; k < 3; k++) begin
            wr(`DSOD_OFS_STEP_CMD, {16'h0, cmds[k]});
            apply_cmd(cmds[k]);
            fsw_chk();
        end
        // Only channel 0 has its pins enabled
        wr(`DSOD_OFS_CTRL, 32'h1001);
        pin_up <= 4'h3;
        repeat (3) @(posedge ref_clk);
        pin_up <= 4'h0;
        acc[0] = acc[0] + {16'h0, stv[0]};
        fsw_chk();
        pin_dn <= 4'h3;
        repeat (3) @(posedge ref_clk);
        pin_dn <= 4'h0;
        acc[0] = acc[0] - {16'h0, stv[0]};
        fsw_chk();
        wr(`DSOD_OFS_CTRL, 32'h2);
        pw = $signed(rnd());
        i_ctrl.put_phase(pw);
        lfi_chk(pw, 20);
        // Rewrite before expiry restarts the timer
        wr(`DSOD_OFS_PSW_TMR, 32'h5);
        wr(`DSOD_OFS_CTRL, 32'h6);
        i_ctrl.put_phase(pw >>> 1);
        repeat (16) @(posedge ref_clk);
        i_ctrl.put_phase(pw >>> 2);
        repeat (36) @(posedge ref_clk);
        check(lfi, pw >>> 2);
        lfi_chk(32'h0, 40);
        wr(`DSOD_OFS_CTRL, 32'he);
        wr(`DSOD_OFS_PSW_TMR, 32'h1);
        i_ctrl.put_phase(-32'sd7);
        for (int i = 0; i < 30 && holdover !== 1'b1; i++)
            @(posedge ref_clk);
        check(holdover, 1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        wr(`DSOD_OFS_CH_SEL, 32'h1);
        wr(`DSOD_OFS_IN_PHOFS, 32'h100);
        wr(`DSOD_OFS_CH_SEL, 32'h2);
        wr(`DSOD_OFS_IN_PHOFS, 32'hffff_ff00);
        wr(`DSOD_OFS_CH_PHOFS, 32'h30);
        pw = $signed(rnd() & 32'hfff);
        active_ref <= 2'h1;
        phase_err <= pw;
        lfi_chk(32'h130 + pw, 20);
        active_ref <= 2'h2;
        lfi_chk(32'hffff_ff30 + pw, 20);
        // Error exactly at threshold counts as inside
        wr(`DSOD_OFS_LOCK_THR, 32'h20);
        wr(`DSOD_OFS_LOCK_INT, 32'h10);
        phase_err <= -32'sd32;
        for (int i = 0; i < 40 && lock_int !== 1'b1; i++)
            @(posedge ref_clk);
        check({lock_int, locked}, 2'b10);
        for (int i = 0; i < 40 && locked !== 1'b1; i++)
            @(posedge ref_clk);
        check(locked, 1'b1);
        phase_err <= 32'sh21;
        repeat (3) @(posedge ref_clk);
        check({lock_int, locked}, 2'b00);
        pw = rnd();
        wr(`DSOD_OFS_FD_INT, pw);
        wr(`DSOD_OFS_FD_FRLO, 32'h10);
        wr(`DSOD_OFS_FD_FRHI, 32'h400);
        repeat (2) @(posedge ref_clk);
        check({fd_int, fd_frac}, {pw, 43'h400_0000_0010});
        wr(`DSOD_OFS_CTRL, 32'h140);
        wr(`DSOD_OFS_NCO_STEP, 32'h6);
        for (int i = 0; i < 20 && fd_frac !== 43'h400_0000_0016; i++)
            @(posedge ref_clk);
        check({fd_src, fd_frac}, {1'b1, 43'h400_0000_0016});
        wr(`DSOD_OFS_CTRL, 32'h1c0);
        wr(`DSOD_OFS_NCO_STEP, 32'h6);
        repeat (20) @(posedge ref_clk);
        check(fd_frac, 43'h400_0000_0016);
        // Sysref follows the divided clock one cycle later
        wr(`DSOD_OFS_CTRL, 32'h20);
        wr(`DSOD_OFS_ID_DIV, 32'h4);
        for (int i = 0; i < 40 && id_clk !== 1'b1; i++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        check(sysref, 1'b1);
        complete_run();
    end
endmodule
bind dsod_core dsod_checker i_chk (.ref_clk(ref_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .locked(locked), .lock_int(lock_int),
    .fd_int(fd_int), .fd_frac(fd_frac));
